// ---- core/hpc_pkg.sv ----
// constants and types shared by the host port control logic
// assumes a single system clock; all pin inputs arrive asynchronously
`default_nettype none
package hpc_pkg;
  // synchronised control pin bit positions
  localparam int CTL_CS = 5;
  localparam int CTL_RD = 4;
  localparam int CTL_WR = 3;
  localparam int CTL_BTS = 2;
  localparam int CTL_SEL = 1;
  localparam int CTL_RSTN = 0;
  localparam int CTL_W = 6;
  // reset value of the control synchroniser: strobes, select and reset idle high
  localparam logic [CTL_W-1:0] CTL_IDLE = 6'h39;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] OE_ALL = 8'hFF;
  localparam logic [7:0] OE_MISO = 8'h01;
  localparam logic [7:0] OE_NONE = 8'h00;
  // serial pin positions on the data bus
  localparam int SPI_SCLK_BIT = 2;
  localparam int SPI_MOSI_BIT = 1;
  localparam int SPI_MISO_BIT = 0;

  typedef enum logic [2:0] {
    HPC_IDLE = 3'b001,
    HPC_READ = 3'b010,
    HPC_WRITE = 3'b100
  } hpc_state_t;
endpackage
`default_nettype wire

// ---- core/hpc_top.sv ----
// host port control: strobe decode, serial pin routing, interrupt tree, reset
// assumes the register file sits on clk_sys_i and returns read data combinationally
`default_nettype none

module hpc_top
  import hpc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int FR_W = 8,
  parameter int LI_W = 8,
  parameter int BE_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic bus_timing_select_i,
  input wire logic serial_port_select_i,
  input wire logic chip_reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] data_in_i,
  input wire logic [7:0] rd_data_i,
  input wire logic spi_miso_i,
  input wire logic [FR_W-1:0] framer_evt_i,
  input wire logic [LI_W-1:0] line_interface_evt_i,
  input wire logic [BE_W-1:0] bit_error_tester_evt_i,
  input wire logic [FR_W-1:0] framer_ack_i,
  input wire logic [LI_W-1:0] line_interface_ack_i,
  input wire logic [BE_W-1:0] bit_error_tester_ack_i,
  input wire logic [FR_W-1:0] framer_mask_i,
  input wire logic [LI_W-1:0] line_interface_mask_i,
  input wire logic [BE_W-1:0] bit_error_tester_mask_i,
  input wire logic global_int_en_i,
  input wire logic framer_int_en_i,
  input wire logic line_interface_int_en_i,
  input wire logic bit_error_tester_int_en_i,
  output logic [7:0] data_out_o,
  output logic [7:0] data_oe_o,
  output logic interrupt_out_n_o,
  output logic interrupt_oe_o,
  output logic wr_en_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic serial_mode_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  output logic core_reset_o
);
  localparam int EV_W = FR_W + LI_W + BE_W;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one is read only by stage two
  logic [CTL_W-1:0] ctl_s1_r, ctl_s2_r;
  logic [ADDR_W-1:0] addr_s1_r, addr_s2_r;
  logic [7:0] data_s1_r, data_s2_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctl_s1_r <= CTL_IDLE;
      ctl_s2_r <= CTL_IDLE;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      data_s1_r <= DATA_RST;
      data_s2_r <= DATA_RST;
    end else begin
      ctl_s1_r <= {chip_select_n_i, read_strobe_n_i, write_strobe_n_i,
                   bus_timing_select_i, serial_port_select_i, chip_reset_n_i};
      ctl_s2_r <= ctl_s1_r;
      addr_s1_r <= addr_i;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_in_i;
      data_s2_r <= data_s1_r;
    end
  end

  logic cs_n_s, rd_pin_s, wr_pin_s, bts_s, sel_s, dev_rst;
  assign cs_n_s = ctl_s2_r[CTL_CS];
  assign rd_pin_s = ctl_s2_r[CTL_RD];
  assign wr_pin_s = ctl_s2_r[CTL_WR];
  assign bts_s = ctl_s2_r[CTL_BTS];
  assign sel_s = ctl_s2_r[CTL_SEL];
  // chip reset pin and system reset both clear the device
  assign dev_rst = rst_i | ~ctl_s2_r[CTL_RSTN];

  ////////////////////////////////////////////////////////////////////////////
  // strobe decode: the pin meaning flips with the timing select
  logic strobe_n, rd_cond, wr_low;
  always_comb begin
    if (bts_s) begin
      strobe_n = rd_pin_s;
      rd_cond = ~rd_pin_s & wr_pin_s & ~cs_n_s;
      wr_low = ~rd_pin_s & ~wr_pin_s & ~cs_n_s;
    end else begin
      strobe_n = wr_pin_s;
      rd_cond = ~rd_pin_s & ~cs_n_s;
      wr_low = ~wr_pin_s & ~cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access state machine and bus drive
  hpc_state_t st_r, st_nxt;
  logic [7:0] hold_r, hold_nxt, dout_r, dout_nxt, doe_r, doe_nxt, wdat_r, wdat_nxt;
  logic wen_r, wen_nxt, ren_r, ren_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt, raddr_r, raddr_nxt;
  logic mode_r, sclk_r, mosi_r;

  always_comb begin
    st_nxt = st_r;
    hold_nxt = hold_r;
    wdat_nxt = wdat_r;
    waddr_nxt = waddr_r;
    raddr_nxt = raddr_r;
    wen_nxt = 1'b0;
    ren_nxt = 1'b0;
    dout_nxt = dout_r;
    doe_nxt = OE_NONE;
    if (sel_s) begin
      // serial mode: parallel machine parked, only the data-out bit driven
      st_nxt = HPC_IDLE;
      dout_nxt = {7'h00, spi_miso_i};
      doe_nxt = cs_n_s ? OE_NONE : OE_MISO;
    end else begin
      case (st_r)
        HPC_IDLE: begin
          if (rd_cond) begin
            st_nxt = HPC_READ;
            raddr_nxt = addr_s2_r;
          end else if (wr_low) begin
            st_nxt = HPC_WRITE;
            hold_nxt = data_s2_r;
            waddr_nxt = addr_s2_r;
          end
        end
        HPC_READ: begin
          // drive only while strobe and select stay low
          if (rd_cond) begin
            ren_nxt = 1'b1;
            dout_nxt = rd_data_i;
            doe_nxt = OE_ALL;
          end else begin
            st_nxt = HPC_IDLE;
          end
        end
        HPC_WRITE: begin
          if (!strobe_n) begin
            hold_nxt = data_s2_r; // last data seen before the rising edge
            waddr_nxt = addr_s2_r;
          end else begin
            st_nxt = HPC_IDLE;
            // a rise with select already high is no access
            wen_nxt = ~cs_n_s;
            wdat_nxt = hold_r;
          end
        end
        default: st_nxt = HPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      st_r <= HPC_IDLE;
      hold_r <= DATA_RST;
      wdat_r <= DATA_RST;
      waddr_r <= '0;
      raddr_r <= '0;
      wen_r <= 1'b0;
      ren_r <= 1'b0;
      dout_r <= DATA_RST;
      doe_r <= OE_NONE;
      mode_r <= 1'b0;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
      wdat_r <= wdat_nxt;
      waddr_r <= waddr_nxt;
      raddr_r <= raddr_nxt;
      wen_r <= wen_nxt;
      ren_r <= ren_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      mode_r <= sel_s;
      sclk_r <= sel_s & data_s2_r[SPI_SCLK_BIT];
      mosi_r <= sel_s & data_s2_r[SPI_MOSI_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt tree; a new event in the ack cycle wins over the ack
  logic [EV_W-1:0] pend_r, pend_nxt, evt_all, ack_all, msk_all;
  logic int_r, int_nxt, fr_hit, li_hit, be_hit, any_hit;

  function automatic logic lvl_hit(input logic [EV_W-1:0] p, input logic [EV_W-1:0] m,
                                   input int lo, input int w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < EV_W; i++) begin
      if (i >= lo && i < lo + w) r = r | (p[i] & ~m[i]);
    end
    return r;
  endfunction

  assign evt_all = {bit_error_tester_evt_i, line_interface_evt_i, framer_evt_i};
  assign ack_all = {bit_error_tester_ack_i, line_interface_ack_i, framer_ack_i};
  assign msk_all = {bit_error_tester_mask_i, line_interface_mask_i, framer_mask_i};

  always_comb begin
    pend_nxt = (pend_r & ~ack_all) | evt_all;
    fr_hit = framer_int_en_i & lvl_hit(pend_r, msk_all, 0, FR_W);
    li_hit = line_interface_int_en_i & lvl_hit(pend_r, msk_all, FR_W, LI_W);
    be_hit = bit_error_tester_int_en_i & lvl_hit(pend_r, msk_all, FR_W + LI_W, BE_W);
    any_hit = global_int_en_i & (fr_hit | li_hit | be_hit);
    int_nxt = any_hit;
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      pend_r <= '0;
      int_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      int_r <= int_nxt;
    end
  end

  logic crst_r;
  always_ff @(posedge clk_sys_i) begin
    crst_r <= dev_rst;
  end

  // open-drain: value always low, enable carries the level
  assign interrupt_out_n_o = 1'b0;
  assign interrupt_oe_o = int_r;
  assign data_out_o = dout_r;
  assign data_oe_o = doe_r;
  assign wr_en_o = wen_r;
  assign wr_addr_o = waddr_r;
  assign wr_data_o = wdat_r;
  assign rd_en_o = ren_r;
  assign rd_addr_o = raddr_r;
  assign serial_mode_o = mode_r;
  assign spi_sclk_o = sclk_r;
  assign spi_mosi_o = mosi_r;
  assign core_reset_o = crst_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wr_pulse_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    wen_r |=> !wen_r) else $error("write pulse longer than one cycle");
  wr_qual_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    wen_r |-> !$past(cs_n_s) && !$past(sel_s)) else $error("write without select");
  mode_sel_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    sel_s |=> mode_r && doe_r[7:1] == 7'h00) else $error("serial mode not taken");
  int_set_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    any_hit |=> interrupt_oe_o) else $error("interrupt not asserted");
  int_release_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    (pend_r == '0) |=> !interrupt_oe_o) else $error("interrupt held with none pending");
  glob_mask_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    !global_int_en_i |=> !interrupt_oe_o) else $error("global mask ignored");
  read_go_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    (st_r == HPC_IDLE && rd_cond && !sel_s) |=> st_r == HPC_READ)
    else $error("read not entered");
  read_drv_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    (st_r == HPC_READ && rd_cond && !sel_s) |=> data_oe_o == OE_ALL)
    else $error("read data not driven");
  cs_float_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    cs_n_s |=> data_oe_o == OE_NONE) else $error("bus driven with select high");
  spi_clk_a: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
    sel_s |=> spi_sclk_o == $past(data_s2_r[SPI_SCLK_BIT])) else $error("serial clock lost");
  rst_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    dev_rst |=> !interrupt_oe_o && !wen_r && core_reset_o)
    else $error("reset left state");
endmodule
`default_nettype wire

// ---- testbench/hpc_host_model.sv ----
// microprocessor model that drives the host port pins
// assumes one bench process calls its task and sets bts_o between accesses
`default_nettype none
module hpc_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic bts_o,
  output logic [9:0] addr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, bts_o} = 4'hE;
    addr_o = 10'h000;
    data_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one access; phases last several clocks so the pin synchroniser sees each one
  task automatic access(input logic wr, input logic sel, input logic [9:0] a,
                        input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    data_o = wr ? d : ~d; // read: device owns the bus, ours is junk
    cs_n_o = ~sel;
    if (bts_o) begin
      wr_n_o = ~wr;
      rd_n_o = 1'b0;
    end else if (wr) begin
      wr_n_o = 1'b0;
    end else begin
      rd_n_o = 1'b0;
    end
    repeat (6) @(negedge clk_i);
    rd_n_o = 1'b1;
    if (!bts_o) wr_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = ~data_o; // released bus must not hold its last value
    repeat (2) @(negedge clk_i);
  endtask
  // static pin levels between accesses: timing style, select and data
  task automatic set_pins(input logic bus_timing_select, input logic cs_n, input logic [7:0] d);
    bts_o = bus_timing_select;
    cs_n_o = cs_n;
    data_o = d;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the host port control block
// assumes the host model drives pins and the bench plays the register file
`default_nettype none
module tb
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst = 1'b1, sel = 1'b0, crst_n = 1'b1, miso = 1'b0, gen = 1'b1;
  logic [2:0] len = 3'h7;
  logic [2:0][7:0] evt = '0, ack = '0, msk = '0;
  logic [7:0] rdd = 8'h00, hd, dout, doe, wdata, v;
  logic [9:0] haddr, waddr, raddr, a, ra;
  logic hcs, hrd, hwr, hbts, io, ioe, wen, ren, smode, sclk, mosi, crst, ren_q = 1'b0;
  logic [17:0] wq[$];
  logic [17:0] rq[$], rnote;
  int n_mismatch = 0, total_checks = 0;
  integer seed = 32'hE32A2078;
  // bus wire: device bits where enabled, host value elsewhere
  wire logic [7:0] dbus = (doe & dout) | (~doe & hd);
  hpc_host_model host (.clk_i(clk), .cs_n_o(hcs), .rd_n_o(hrd), .wr_n_o(hwr),
    .bts_o(hbts), .addr_o(haddr), .data_o(hd));
  hpc_top dut (.clk_sys_i(clk), .rst_i(rst), .chip_select_n_i(hcs), .read_strobe_n_i(hrd),
    .write_strobe_n_i(hwr), .bus_timing_select_i(hbts), .serial_port_select_i(sel),
    .chip_reset_n_i(crst_n), .addr_i(haddr), .data_in_i(dbus), .rd_data_i(rdd),
    .spi_miso_i(miso), .framer_evt_i(evt[0]), .line_interface_evt_i(evt[1]),
    .bit_error_tester_evt_i(evt[2]), .framer_ack_i(ack[0]), .line_interface_ack_i(ack[1]),
    .bit_error_tester_ack_i(ack[2]), .framer_mask_i(msk[0]), .line_interface_mask_i(msk[1]),
    .bit_error_tester_mask_i(msk[2]), .global_int_en_i(gen), .framer_int_en_i(len[0]),
    .line_interface_int_en_i(len[1]), .bit_error_tester_int_en_i(len[2]),
    .data_out_o(dout), .data_oe_o(doe), .interrupt_out_n_o(io), .interrupt_oe_o(ioe),
    .wr_en_o(wen), .wr_addr_o(waddr), .wr_data_o(wdata), .rd_en_o(ren), .rd_addr_o(raddr),
    .serial_mode_o(smode), .spi_sclk_o(sclk), .spi_mosi_o(mosi), .core_reset_o(crst));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one interrupt try: c = {global, level enable, masked, expected}
  task automatic int_try(input int l, input logic [3:0] c);
    logic [7:0] b;
    b = 8'h01 << ($random(seed) & 7);
    gen = c[3];
    len[l] = c[2];
    msk[l] = c[1] ? b : 8'h00;
    evt[l] = b;
    @(negedge clk) evt[l] = 8'h00;
    repeat (3) @(negedge clk);
    chk("interrupt", {17'h0, c[0]}, {17'h0, ioe});
    ack[l] = b;
    @(negedge clk) ack[l] = 8'h00;
    repeat (3) @(negedge clk);
    chk("release", 18'h0, {17'h0, ioe});
    {gen, len[l], msk[l]} = 10'h300;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // result watcher: every write pulse and read start must match the oldest note
  always @(negedge clk) begin
    if (wen === 1'b1) begin
      if (wq.size() == 0) chk("stray write", 18'h0, 18'h1);
      else chk("write", wq.pop_front(), {waddr, wdata});
    end
    if (ren === 1'b1 && ren_q !== 1'b1) begin
      if (rq.size() == 0) chk("stray read", 18'h0, 18'h1);
      else begin
        rnote = rq.pop_front();
        chk("read", rnote, {raddr, dout});
        chk("read drive", {10'h0, OE_ALL}, {10'h0, doe});
      end
    end
    ren_q <= ren;
  end
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("int after reset", 18'h0, {17'h0, ioe});
    for (int b = 0; b < 2; b++) begin
      host.set_pins(b[0], 1'b1, hd);
      repeat (4) @(negedge clk);
      for (int i = 0; i < 3; i++) begin
        a = 10'($random(seed));
        v = 8'($random(seed));
        wq.push_back({a, v});
        host.access(1'b1, 1'b1, a, v);
        rdd = 8'($random(seed));
        ra = 10'($random(seed));
        rq.push_back({ra, rdd});
        host.access(1'b0, 1'b1, ra, 8'h00);
        chk("bus idle", {10'h0, OE_NONE}, {10'h0, doe});
      end
      host.access(1'b1, 1'b0, a, v);
    end
    // serial mode: pins routed, parallel strobes ignored
    sel = 1'b1;
    host.set_pins(1'b0, 1'b0, hd);
    for (int k = 0; k < 4; k++) begin
      host.set_pins(1'b0, 1'b0, 8'($random(seed)));
      miso = ~miso;
      repeat (4) @(negedge clk);
      chk("serial miso", {17'h0, miso}, {17'h0, dout[0]});
      chk("serial pins", {16'h0, hd[2:1]}, {16'h0, sclk, mosi});
      chk("serial oe", {10'h0, OE_MISO}, {10'h0, doe});
      chk("serial mode", 18'h1, {17'h0, smode});
    end
    host.set_pins(1'b0, 1'b1, hd);
    repeat (4) @(negedge clk);
    chk("serial idle", {10'h0, OE_NONE}, {10'h0, doe});
    host.access(1'b1, 1'b1, a, v);
    sel = 1'b0;
    repeat (4) @(negedge clk);
    // interrupt tree: each level fully enabled, then with global enable, level enable or mask each blocking alone
    for (int l = 0; l < 3; l++) begin
      int_try(l, 4'hD);
      int_try(l, 4'h4);
      int_try(l, 4'h8);
      int_try(l, 4'hE);
    end
    chk("open drain value", 18'h0, {17'h0, io});
    // device reset drops a pending interrupt
    // two sources pending, only one acknowledged: pin must stay asserted
    {evt[1], evt[0]} = 16'h8001;
    @(negedge clk);
    {evt[1], evt[0]} = 16'h0000;
    ack[0] = 8'h01;
    @(negedge clk);
    ack[0] = 8'h00;
    repeat (3) @(negedge clk);
    chk("pending", 18'h1, {17'h0, ioe});
    crst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("core reset", 18'h1, {17'h0, crst});
    crst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("core reset end", 18'h0, {17'h0, crst});
    chk("int cleared", 18'h0, {17'h0, ioe});
    chk("notes left", 18'h0, 18'(wq.size() + rq.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
